// ==== rtl/reset_recovery_cfg.svh ====
// timing, field and reset-value constants for the reset recovery block
`ifndef RESET_RECOVERY_CFG_SVH
`define RESET_RECOVERY_CFG_SVH
`define RR_PULSE_TOTAL 3'h4
`define RR_SR1_DEFAULT 8'h00
`define RR_CR1_DEFAULT 8'h00
`define RR_CR2_DEFAULT 8'h00
`define RR_CR4_DEFAULT 8'h08
`define RR_CR5_DEFAULT 8'h00
`define RR_ZERO8 8'h00
`define RR_ZERO24 24'h000000
`define RR_WEL_BIT 1
`define RR_WIP_BIT 0
`define RR_PU_TIME_NS 450000
`define RR_CLK_PERIOD_NS 5
`define RR_PU_CYCLES ((`RR_PU_TIME_NS + `RR_CLK_PERIOD_NS - 1) / `RR_CLK_PERIOD_NS)
`endif

// ==== rtl/reset_recovery_pkg.sv ====
// types for the reset recovery block
package reset_recovery_pkg;
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_LOW = 3'b010,
        SEQ_HIGH = 3'b100
    } seq_state_t;
endpackage

// ==== rtl/spi_signaled_reset_recovery.sv ====
// signaling reset detector and register reset controller of a serial memory
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - signaling reset accepted in any I/O width
// - reset fires on fourth chip select rise
// - pin and signaling resets tristate; all hard resets load defaults, clear
// - stuck busy after power-up marks failed boot
// - deep power-down zeroes ECC count, trap
// - hibernate exit reloads power-up values
// - reset enable then reset; others cancel
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "reset_recovery_cfg.svh"

module spi_signaled_reset_recovery #(
    parameter int PU_CYCLES = `RR_PU_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // pins
    input wire logic chipSelect_n,
    input wire logic dataLine0,
    input wire logic hwReset_n,
    // command decoder events, one-cycle pulses, and the boot busy level
    input wire logic cmdValid,
    input wire logic cmdResetEnable,
    input wire logic cmdReset,
    input wire logic dpdExit,
    input wire logic hibernateExit,
    input wire logic bootBusy,
    // register write port from the command side
    input wire logic regWrite,
    input wire logic [2:0] regSelect,
    input wire logic [7:0] regWriteData,
    // register state
    output logic [7:0] statusRegOne,
    output logic [7:0] statusRegTwo,
    output logic [7:0] configRegOne,
    output logic [7:0] configRegTwo,
    output logic [7:0] configRegFour,
    output logic [7:0] configRegFive,
    output logic [7:0] eccStatus,
    output logic [7:0] crcReg,
    output logic [7:0] eccErrorCount,
    output logic [23:0] eccFaultAddress,
    // status
    output logic outputsTristate,
    output logic inputsIgnored,
    output logic bootFailed,
    output logic resetPulse
);
    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers, three stages, agreement of the last two
    logic [2:0] csSync, d0Sync, hrSync;
    logic csClean, d0Clean, hrClean;
    logic [2:0] next_csSync, next_d0Sync, next_hrSync;
    logic next_csClean, next_d0Clean, next_hrClean;

    always_comb begin
        next_csSync = {csSync[1:0], chipSelect_n};
        next_d0Sync = {d0Sync[1:0], dataLine0};
        next_hrSync = {hrSync[1:0], hwReset_n};
        next_csClean = (csSync[2] == csSync[1]) ? csSync[2] : csClean;
        next_d0Clean = (d0Sync[2] == d0Sync[1]) ? d0Sync[2] : d0Clean;
        next_hrClean = (hrSync[2] == hrSync[1]) ? hrSync[2] : hrClean;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            csSync <= 3'h7;
            d0Sync <= 3'h0;
            hrSync <= 3'h7;
            csClean <= 1'h1;
            d0Clean <= 1'h0;
            hrClean <= 1'h1;
        end else begin
            csSync <= next_csSync;
            d0Sync <= next_d0Sync;
            hrSync <= next_hrSync;
            csClean <= next_csClean;
            d0Clean <= next_d0Clean;
            hrClean <= next_hrClean;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // signaling reset detector; independent of the serial clock and width
    reset_recovery_pkg::seq_state_t seqState, next_seqState;
    logic [2:0] pulseCount, next_pulseCount;
    logic lastLevel, next_lastLevel;
    logic csPrev, next_csPrev;
    logic seqFire;
    logic csFall, csRise;

    assign csFall = csPrev && !csClean;
    assign csRise = !csPrev && csClean;

    always_comb begin
        next_seqState = seqState;
        next_pulseCount = pulseCount;
        next_lastLevel = lastLevel;
        next_csPrev = csClean;
        seqFire = 1'b0;
        case (seqState)
            reset_recovery_pkg::SEQ_IDLE: begin
                if (csFall) begin
                    next_seqState = reset_recovery_pkg::SEQ_LOW;
                    next_pulseCount = 3'h1;
                    next_lastLevel = d0Clean;
                end
            end
            reset_recovery_pkg::SEQ_LOW: begin
                if (csRise) begin
                    if (d0Clean) begin // data line must be low at rise
                        next_seqState = reset_recovery_pkg::SEQ_IDLE;
                        next_pulseCount = 3'h0;
                    end else if (pulseCount == `RR_PULSE_TOTAL) begin
                        seqFire = 1'b1;
                        next_seqState = reset_recovery_pkg::SEQ_IDLE;
                        next_pulseCount = 3'h0;
                    end else begin
                        next_seqState = reset_recovery_pkg::SEQ_HIGH;
                    end
                end
            end
            reset_recovery_pkg::SEQ_HIGH: begin
                if (csFall) begin
                    next_seqState = reset_recovery_pkg::SEQ_LOW;
                    if (d0Clean != lastLevel) begin // alternation
                        next_pulseCount = pulseCount + 3'h1;
                    end else begin
                        next_pulseCount = 3'h1; // restart a new sequence
                    end
                    next_lastLevel = d0Clean;
                end
            end
            default: begin
                next_seqState = reset_recovery_pkg::SEQ_IDLE;
                next_pulseCount = 3'h0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            seqState <= reset_recovery_pkg::SEQ_IDLE;
            pulseCount <= 3'h0;
            lastLevel <= 1'h0;
            csPrev <= 1'h1;
        end else begin
            seqState <= next_seqState;
            pulseCount <= next_pulseCount;
            lastLevel <= next_lastLevel;
            csPrev <= next_csPrev;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // software reset arming and power-up watch
    logic resetArmed, next_resetArmed;
    logic softFire;
    logic [31:0] puCount, next_puCount;
    logic next_bootFailed;

    always_comb begin
        next_resetArmed = resetArmed;
        softFire = 1'b0;
        if (cmdValid) begin
            if (cmdResetEnable) begin
                next_resetArmed = 1'b1;
            end else if (cmdReset && resetArmed) begin
                softFire = 1'b1;
                next_resetArmed = 1'b0;
            end else begin
                next_resetArmed = 1'b0; // any other command cancels
            end
        end
        next_puCount = (puCount < 32'(PU_CYCLES)) ? puCount + 32'h1 : puCount;
        // busy still shown after power-up time means failed boot
        next_bootFailed = (puCount >= 32'(PU_CYCLES)) && bootBusy;
    end

    //////////////////////////////////////////////////////////////////////////
    // register state under each reset kind
    logic hardFire;
    logic [7:0] next_statusRegOne, next_statusRegTwo, next_configRegOne;
    logic [7:0] next_configRegTwo, next_configRegFour, next_configRegFive;
    logic [7:0] next_eccStatus, next_crcReg, next_eccErrorCount;
    logic [23:0] next_eccFaultAddress;
    logic next_outputsTristate, next_inputsIgnored;

    // hardware pin, signaling sequence or hibernate exit, all always available
    assign hardFire = !hrClean || seqFire || hibernateExit;

    always_comb begin
        next_statusRegOne = statusRegOne;
        next_statusRegTwo = statusRegTwo;
        next_configRegOne = configRegOne;
        next_configRegTwo = configRegTwo;
        next_configRegFour = configRegFour;
        next_configRegFive = configRegFive;
        next_eccStatus = eccStatus;
        next_crcReg = crcReg;
        next_eccErrorCount = eccErrorCount;
        next_eccFaultAddress = eccFaultAddress;
        next_outputsTristate = !hrClean || seqFire;
        next_inputsIgnored = !hrClean || seqFire;
        if (regWrite) begin
            case (regSelect)
                3'h0: next_statusRegOne = regWriteData;
                3'h1: next_statusRegTwo = regWriteData;
                3'h2: next_configRegOne = regWriteData;
                3'h3: next_configRegTwo = regWriteData;
                3'h4: next_configRegFour = regWriteData;
                3'h5: next_configRegFive = regWriteData;
                default: next_eccStatus = regWriteData;
            endcase
        end
        if (dpdExit) begin
            next_eccErrorCount = `RR_ZERO8;
            next_eccFaultAddress = `RR_ZERO24;
            next_crcReg = `RR_ZERO8;
            next_statusRegOne[`RR_WEL_BIT] = 1'b0;
        end
        if (hardFire) begin
            // power-up values; also used on hibernate exit
            next_statusRegOne = `RR_SR1_DEFAULT;
            next_configRegOne = `RR_CR1_DEFAULT;
            next_configRegTwo = `RR_CR2_DEFAULT;
            next_configRegFour = `RR_CR4_DEFAULT;
            next_configRegFive = `RR_CR5_DEFAULT;
        end else if (softFire) begin
            next_statusRegOne[`RR_WEL_BIT] = 1'b0; // config kept
        end
        if (hardFire || softFire) begin
            next_statusRegTwo = `RR_ZERO8;
            next_eccStatus = `RR_ZERO8;
            next_crcReg = `RR_ZERO8;
            next_eccErrorCount = `RR_ZERO8;
            next_eccFaultAddress = `RR_ZERO24;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            statusRegOne <= `RR_SR1_DEFAULT;
            statusRegTwo <= `RR_ZERO8;
            configRegOne <= `RR_CR1_DEFAULT;
            configRegTwo <= `RR_CR2_DEFAULT;
            configRegFour <= `RR_CR4_DEFAULT;
            configRegFive <= `RR_CR5_DEFAULT;
            eccStatus <= `RR_ZERO8;
            crcReg <= `RR_ZERO8;
            eccErrorCount <= `RR_ZERO8;
            eccFaultAddress <= `RR_ZERO24;
            outputsTristate <= 1'h1;
            inputsIgnored <= 1'h1;
            bootFailed <= 1'h0;
            resetPulse <= 1'h0;
            resetArmed <= 1'h0;
            puCount <= 32'h0;
        end else begin
            statusRegOne <= next_statusRegOne;
            statusRegTwo <= next_statusRegTwo;
            configRegOne <= next_configRegOne;
            configRegTwo <= next_configRegTwo;
            configRegFour <= next_configRegFour;
            configRegFive <= next_configRegFive;
            eccStatus <= next_eccStatus;
            crcReg <= next_crcReg;
            eccErrorCount <= next_eccErrorCount;
            eccFaultAddress <= next_eccFaultAddress;
            outputsTristate <= next_outputsTristate;
            inputsIgnored <= next_inputsIgnored;
            bootFailed <= next_bootFailed;
            resetPulse <= hardFire || softFire;
            resetArmed <= next_resetArmed;
            puCount <= next_puCount;
        end
    end
endmodule

// ==== tb/spi_signaled_reset_recovery_assertions.sv ====
// port checker for the reset recovery block
`timescale 1ns/1ps
`include "reset_recovery_cfg.svh"
module reset_recovery_checker #(parameter int PU_CYCLES = `RR_PU_CYCLES) (
    // clock, reset and events
    input wire logic mclk,
    input wire logic srst,
    input wire logic hwReset_n,
    input wire logic cmdValid,
    input wire logic cmdResetEnable,
    input wire logic cmdReset,
    input wire logic dpdExit,
    input wire logic hibernateExit,
    // register state and status
    input wire logic [7:0] statusRegOne,
    input wire logic [7:0] statusRegTwo,
    input wire logic [7:0] configRegFour,
    input wire logic [7:0] crcReg,
    input wire logic [7:0] eccErrorCount,
    input wire logic [23:0] eccFaultAddress,
    input wire logic outputsTristate,
    input wire logic inputsIgnored,
    input wire logic bootFailed,
    input wire logic resetPulse
);
    int upTime;
    int next_upTime;
    // saturating cycle count since reset release
    always_comb next_upTime = (upTime < PU_CYCLES) ? upTime + 1 : upTime;
    always_ff @(posedge mclk) upTime <= srst ? 0 : next_upTime;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    soft_reset_a: assert property (
        $past(cmdValid && cmdResetEnable) && cmdValid && cmdReset |-> ##[0:2] resetPulse)
        else $error("armed reset gave no pulse");
    pulse_clears_a: assert property (
        resetPulse |-> statusRegTwo == 8'h00 && crcReg == 8'h00 && eccErrorCount == 8'h00
            && eccFaultAddress == 24'h000000 && !statusRegOne[`RR_WEL_BIT])
        else $error("reset left state");
    release_state_a: assert property (
        $fell(srst) |-> outputsTristate && configRegFour == `RR_CR4_DEFAULT)
        else $error("bad state at release");
    tristate_pair_a: assert property (
        !hwReset_n [*6] |-> outputsTristate && inputsIgnored)
        else $error("hardware reset left outputs driven");
    hw_defaults_a: assert property (
        !hwReset_n [*6] |-> configRegFour == `RR_CR4_DEFAULT && statusRegTwo == 8'h00)
        else $error("hardware reset kept state");
    dpd_exit_a: assert property (
        dpdExit |=> eccErrorCount == 8'h00 && eccFaultAddress == 24'h000000
            && !statusRegOne[`RR_WEL_BIT])
        else $error("power-down exit kept counts");
    hib_exit_a: assert property (
        hibernateExit |=> statusRegOne == `RR_SR1_DEFAULT && configRegFour == `RR_CR4_DEFAULT)
        else $error("hibernate exit kept state");
    boot_fail_a: assert property ($rose(bootFailed) |-> upTime >= PU_CYCLES - 1)
        else $error("boot failure flagged early");
    sig_reset_c: cover property (resetPulse && !$past(cmdValid));
    boot_fail_c: cover property ($rose(bootFailed));
    hw_reset_c: cover property ($fell(hwReset_n));
endmodule
bind spi_signaled_reset_recovery reset_recovery_checker #(.PU_CYCLES(PU_CYCLES)) chk (
    .mclk(mclk),
    .srst(srst),
    .hwReset_n(hwReset_n),
    .cmdValid(cmdValid),
    .cmdResetEnable(cmdResetEnable),
    .cmdReset(cmdReset),
    .dpdExit(dpdExit),
    .hibernateExit(hibernateExit),
    .statusRegOne(statusRegOne),
    .statusRegTwo(statusRegTwo),
    .configRegFour(configRegFour),
    .crcReg(crcReg),
    .eccErrorCount(eccErrorCount),
    .eccFaultAddress(eccFaultAddress),
    .outputsTristate(outputsTristate),
    .inputsIgnored(inputsIgnored),
    .bootFailed(bootFailed),
    .resetPulse(resetPulse)
);

// ==== tb/reset_host_model.sv ====
// host model sending chip-select reset frames
`timescale 1ns/1ps
module reset_host_model (
    // clock
    input wire logic mclk,
    // pins toward the device
    output logic chipSelect_n,
    output logic dataLine0
);
    logic busy = 1'h0;
    initial chipSelect_n = 1'h1;
    initial dataLine0 = 1'h0;
    // released data line changes every cycle
    always @(posedge mclk) if (!busy) dataLine0 <= #1 ~dataLine0;
    // frames with the serial clock held still
    task automatic frames(input int abortAt);
        busy = 1'h1;
        for (int i = 0; i < 4; i++) begin  // four pulses
            repeat (4) @(posedge mclk);
            #1 chipSelect_n = 1'h0;  // select
            dataLine0 = ~i[0];  // alternating level at fall
            repeat (4) @(posedge mclk);
            #1 dataLine0 = (i == abortAt);  // low before deselect, high on pulse abortAt
            repeat (4) @(posedge mclk);
            #1 chipSelect_n = 1'h1;
        end
        busy = 1'h0;
    endtask
endmodule

// ==== tb/spi_signaled_reset_recovery_bench.sv ====
// self-checking bench for the reset recovery block
`timescale 1ns/1ps
`include "reset_recovery_cfg.svh"
module spi_signaled_reset_recovery_bench;
    logic mclk = 1'h0, srst = 1'h1, hwReset_n = 1'h1, bootBusy = 1'h1, regWrite = 1'h0;
    logic cmdValid = 1'h0, cmdResetEnable = 1'h0, cmdReset = 1'h0, dpdExit = 1'h0;
    logic hibernateExit = 1'h0, chipSelect_n, dataLine0;
    logic outputsTristate, inputsIgnored, bootFailed, resetPulse;
    logic [2:0] regSelect = 3'h0;
    logic [7:0] regWriteData = 8'h00, statusRegOne, statusRegTwo, configRegOne, configRegTwo;
    logic [7:0] configRegFour, configRegFive, eccStatus, crcReg, eccErrorCount;
    logic [23:0] eccFaultAddress;
    int n_errors = 0, total_checks = 0, cycles = 0;
    int m[7];
    always #2.5 mclk = ~mclk;
    reset_host_model host (.mclk(mclk), .chipSelect_n(chipSelect_n), .dataLine0(dataLine0));
    spi_signaled_reset_recovery #(.PU_CYCLES(20)) DUT (
        .mclk(mclk),
        .srst(srst),
        .chipSelect_n(chipSelect_n),
        .dataLine0(dataLine0),
        .hwReset_n(hwReset_n),
        .cmdValid(cmdValid),
        .cmdResetEnable(cmdResetEnable),
        .cmdReset(cmdReset),
        .dpdExit(dpdExit),
        .hibernateExit(hibernateExit),
        .bootBusy(bootBusy),
        .regWrite(regWrite),
        .regSelect(regSelect),
        .regWriteData(regWriteData),
        .statusRegOne(statusRegOne),
        .statusRegTwo(statusRegTwo),
        .configRegOne(configRegOne),
        .configRegTwo(configRegTwo),
        .configRegFour(configRegFour),
        .configRegFive(configRegFive),
        .eccStatus(eccStatus),
        .crcReg(crcReg),
        .eccErrorCount(eccErrorCount),
        .eccFaultAddress(eccFaultAddress),
        .outputsTristate(outputsTristate),
        .inputsIgnored(inputsIgnored),
        .bootFailed(bootFailed),
        .resetPulse(resetPulse)
    );
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic defaults();
        m = '{`RR_SR1_DEFAULT, 0, `RR_CR1_DEFAULT, `RR_CR2_DEFAULT, `RR_CR4_DEFAULT,
            `RR_CR5_DEFAULT, 0};
    endtask
    task automatic check_regs();
        check({statusRegOne, statusRegTwo, configRegOne, configRegTwo, configRegFour,
            configRegFive, eccStatus, crcReg, eccErrorCount, eccFaultAddress},
            {8'(m[0]), 8'(m[1]), 8'(m[2]), 8'(m[3]), 8'(m[4]), 8'(m[5]), 8'(m[6]), 40'h0});
    endtask
    // back-to-back random writes, write latch kept set
    task automatic scramble();
        for (int i = 0; i < 8; i++) begin
            regSelect = 3'($urandom_range(7));
            regWriteData = 8'($urandom) | 8'h02;
            regWrite = 1'h1;
            m[regSelect < 3'h6 ? regSelect : 3'h6] = regWriteData;
            tick(1);
        end
        regWrite = 1'h0;
        tick(1);
    endtask
    task automatic cmd(input logic en, input logic rs);
        cmdValid = 1'h1;
        cmdResetEnable = en;
        cmdReset = rs;
        tick(1);
    endtask
    task automatic wait_pulse(input logic exp);
        logic got = 1'h0;
        for (int i = 0; i < 20 && !got; i++) begin
            got = resetPulse;
            if (!got) tick(1);
        end
        check(got, exp);
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 3000) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'h922b));
        defaults();
        tick(5);
        srst = 1'h0;
        tick(1);
        check({outputsTristate, inputsIgnored}, 2'h0);
        check_regs();
        tick(25);
        check(bootFailed, 1'h1);
        bootBusy = 1'h0;
        // lone reset, cancelled enable, then armed pair
        scramble();
        cmd(1'h0, 1'h1);
        cmdValid = 1'h0;
        wait_pulse(1'h0);
        cmd(1'h1, 1'h0);
        cmd(1'h0, 1'h0);
        cmd(1'h0, 1'h1);
        cmdValid = 1'h0;
        wait_pulse(1'h0);
        cmd(1'h1, 1'h0);
        cmd(1'h0, 1'h1);
        cmdValid = 1'h0;
        wait_pulse(1'h1);
        m[0] &= ~(1 << `RR_WEL_BIT);
        m[1] = 0;
        m[6] = 0;
        check_regs();
        // fourth pulse aborted by a high data line, then a full set
        for (int k = 0; k < 2; k++) begin
            scramble();
            host.frames(k == 0 ? 3 : 4);
            wait_pulse(k == 1);
            check({outputsTristate, inputsIgnored}, {2{k == 1}});
            if (k == 1) defaults();
            check_regs();
        end
        scramble();
        hwReset_n = 1'h0;
        tick(8);
        check({outputsTristate, inputsIgnored}, 2'h3);
        hwReset_n = 1'h1;
        tick(6);
        defaults();
        check_regs();
        scramble();
        dpdExit = 1'h1;
        tick(1);
        dpdExit = 1'h0;
        tick(1);
        m[0] &= ~(1 << `RR_WEL_BIT);
        check_regs();
        hibernateExit = 1'h1;
        tick(1);
        hibernateExit = 1'h0;
        tick(1);
        defaults();
        check_regs();
        give_verdict();
    end
endmodule
